// [hdl/aps_regs.sv]
// Purpose: negotiation page registers behind a management serial port
// Assumes: mdc and mdio come from pins and are resynchronised here
// Notes:   line-side events arrive on clk_in as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1: advertisement stored now, applied on trigger
// R2: advertisement bit 9 reads zero always
// R3: advertisement bit 10 holds symmetric pause
// R4: partner bit15 next page, cleared by reset
// R5: partner bit14 holds received acknowledge
// R6: partner bit13 holds received remote fault
// R7: partner bits 11,10 hold partner pause
// R8: partner bits 9:5 hold technology bits
// R9: partner bits 4:0 hold selector field
// R10: parallel fault latches, read clears
// R11: partner next page ability latches high
// R12: local next page ability reads one
// R13: new page flag latches, read clears
// R14: partner negotiation ability shown live
// R15: transmit bit15 writable more-pages flag
// R16: message flag selects code meaning
// R17: transmit bit12 writable second acknowledge
// R18: toggle bit inverts previous exchanged toggle
// R19: received next page word read only
// R20: configuration fault latches, clears three ways
// R21: bit14 shows master resolution
// R22: idle error counter clears on read
// R23: host keeps management clock at or below 12.5 MHz
// R24: writes to read-only fields ignored
module aps_regs #(
   parameter logic [4:0] PHY_ADDR = 5'h00
) (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              rstn_in,
   // management pins
   input  wire logic              mdc_in,
   input  wire logic              mdio_in,
   output logic                   mdio_out,
   output logic                   mdio_oe_out,
   // line-side negotiation logic
   input  wire aps_pkg::aps_line_s  line_in,
   input  wire aps_pkg::aps_apply_s apply_in,
   output logic [15:0]            adv_active_out,
   output logic [15:0]            tx_next_page_out
);

   // pin synchronisers; the second stage is read, and mdc_d delays mdc once more for edge detect
   logic mdc_s1, mdc_s2, mdc_d, mdio_s1, mdio_s2;
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         mdc_s1  <= 1'b0;
         mdc_s2  <= 1'b0;
         mdc_d   <= 1'b0;
         mdio_s1 <= 1'b1;
         mdio_s2 <= 1'b1;
      end else begin
         mdc_s1  <= mdc_in;
         mdc_s2  <= mdc_s1;
         mdc_d   <= mdc_s2;
         mdio_s1 <= mdio_in;
         mdio_s2 <= mdio_s1;
      end
   end
   // host clock is slow enough that each high phase spans several cycles [R23]
   wire logic rise = mdc_s2 & ~mdc_d;

   // frame engine state
   aps_pkg::aps_state_e st, next_st;
   logic [4:0]  cnt, next_cnt;
   logic [15:0] sh, next_sh;
   logic [15:0] rd_sh, next_rd_sh;
   logic [4:0]  addr, next_addr;
   logic        is_rd, next_is_rd;
   logic        prev, next_prev;
   logic        rd_stb, next_rd_stb;
   logic        wr_stb, next_wr_stb;
   logic [15:0] wr_data, next_wr_data;
   logic        next_mdio_out, next_mdio_oe;
   logic [15:0] rd_data;
   logic [12:0] hdr;

   // frame engine: start detect, header, turnaround, data
   always_comb begin
      next_st      = st;
      next_cnt     = cnt;
      next_sh      = sh;
      next_rd_sh   = rd_sh;
      next_addr    = addr;
      next_is_rd   = is_rd;
      next_prev    = prev;
      next_rd_stb  = 1'b0;
      next_wr_stb  = 1'b0;
      next_wr_data = wr_data;
      next_mdio_out = mdio_out;
      next_mdio_oe  = mdio_oe_out;
      hdr = {sh[11:0], mdio_s2};
      // read data is captured once, so flags cleared by this read stay visible
      if (rd_stb) begin
         next_rd_sh = rd_data;
      end
      if (rise) begin
         case (st)
            aps_pkg::APS_IDLE: begin
               next_prev = mdio_s2;
               if (prev && !mdio_s2) begin
                  next_st  = aps_pkg::APS_HDR;
                  next_cnt = aps_pkg::CNT_ZERO;
               end
            end
            aps_pkg::APS_HDR: begin
               next_sh  = {sh[14:0], mdio_s2};
               next_cnt = cnt + aps_pkg::CNT_INC;
               if (cnt == aps_pkg::HDR_LAST) begin
                  next_cnt  = aps_pkg::CNT_ZERO;
                  next_addr = hdr[4:0];
                  next_is_rd = (hdr[11:10] == aps_pkg::OP_READ);
                  next_prev = 1'b0;
                  // foreign address or bad opcode: stay quiet until next start
                  if (hdr[12] && hdr[9:5] == PHY_ADDR &&
                      (hdr[11:10] == aps_pkg::OP_READ ||
                       hdr[11:10] == aps_pkg::OP_WRITE)) begin
                     next_st     = aps_pkg::APS_TURN;
                     next_rd_stb = (hdr[11:10] == aps_pkg::OP_READ);
                  end else begin
                     next_st = aps_pkg::APS_IDLE;
                  end
               end
            end
            aps_pkg::APS_TURN: begin
               next_cnt = cnt + aps_pkg::CNT_INC;
               if (is_rd && cnt == aps_pkg::CNT_ZERO) begin
                  next_mdio_oe  = 1'b1;
                  next_mdio_out = 1'b0;
               end
               if (cnt == aps_pkg::TA_LAST) begin
                  next_st  = aps_pkg::APS_DATA;
                  next_cnt = aps_pkg::CNT_ZERO;
                  if (is_rd) begin
                     next_mdio_out = rd_sh[15];
                     next_rd_sh    = {rd_sh[14:0], 1'b0};
                  end
               end
            end
            aps_pkg::APS_DATA: begin
               next_cnt = cnt + aps_pkg::CNT_INC;
               next_sh  = {sh[14:0], mdio_s2};
               if (is_rd) begin
                  next_mdio_out = rd_sh[15];
                  next_rd_sh    = {rd_sh[14:0], 1'b0};
               end
               if (cnt == aps_pkg::DAT_LAST) begin
                  next_st       = aps_pkg::APS_IDLE;
                  next_mdio_oe  = 1'b0;
                  next_mdio_out = 1'b0;
                  next_wr_stb   = !is_rd;
                  next_wr_data  = {sh[14:0], mdio_s2};
               end
            end
            default: begin
               next_st      = aps_pkg::APS_IDLE;
               next_mdio_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         st          <= aps_pkg::APS_IDLE;
         cnt         <= 5'h00;
         sh          <= 16'h0000;
         rd_sh       <= 16'h0000;
         addr        <= 5'h00;
         is_rd       <= 1'b0;
         prev        <= 1'b0;
         rd_stb      <= 1'b0;
         wr_stb      <= 1'b0;
         wr_data     <= 16'h0000;
         mdio_out    <= 1'b0;
         mdio_oe_out <= 1'b0;
      end else begin
         st          <= next_st;
         cnt         <= next_cnt;
         sh          <= next_sh;
         rd_sh       <= next_rd_sh;
         addr        <= next_addr;
         is_rd       <= next_is_rd;
         prev        <= next_prev;
         rd_stb      <= next_rd_stb;
         wr_stb      <= next_wr_stb;
         wr_data     <= next_wr_data;
         mdio_out    <= next_mdio_out;
         mdio_oe_out <= next_mdio_oe;
      end
   end

   // register state
   logic [15:0] adv, next_adv, next_adv_active;
   logic [15:0] pbase, next_pbase;
   logic [15:0] txnp, next_txnp;
   logic [15:0] rxnp, next_rxnp;
   logic        exp_pd, exp_lpnp, exp_pg, an_cmp_d, ms_fault_f;
   logic        next_exp_pd, next_exp_lpnp, next_exp_pg, next_ms_fault_f;
   logic [7:0]  idle_cnt, next_idle_cnt;
   logic        apply_now, rd_exp, rd_ms;

   // read view; reserved and unsupported bits read as zero
   always_comb begin
      case (addr)
         aps_pkg::ADV_ADDR:   rd_data = adv;
         aps_pkg::PBASE_ADDR: rd_data = pbase;
         aps_pkg::EXP_ADDR:   rd_data = {11'h000, exp_pd, exp_lpnp, 1'b1,  // [R12]
                                         exp_pg, line_in.lp_an_able};     // [R14]
         aps_pkg::TXNP_ADDR:  rd_data = txnp;
         aps_pkg::RXNP_ADDR:  rd_data = rxnp;                             // [R19]
         aps_pkg::MS_ADDR:    rd_data = {ms_fault_f, line_in.ms_master,   // [R21]
                                         6'h00, idle_cnt};
         default:             rd_data = aps_pkg::ZERO16;
      endcase
   end

   // register updates; hardware set always beats a read clear
   always_comb begin
      apply_now = apply_in.sw_reset | apply_in.an_restart |
                  apply_in.power_up | apply_in.link_down;
      rd_exp = rd_stb && addr == aps_pkg::EXP_ADDR;
      rd_ms  = rd_stb && addr == aps_pkg::MS_ADDR;
      next_adv = adv;
      next_txnp = txnp;
      // only writable bits take host data; the rest keep their value [R24]
      if (wr_stb && addr == aps_pkg::ADV_ADDR) begin
         next_adv = (adv & ~aps_pkg::ADV_WR_MASK) |
                    (wr_data & aps_pkg::ADV_WR_MASK);       // [R1] [R3] [R2]
      end
      if (wr_stb && addr == aps_pkg::TXNP_ADDR) begin
         next_txnp = (txnp & ~aps_pkg::TXNP_WR_MSK) |
                     (wr_data & aps_pkg::TXNP_WR_MSK);      // [R15] [R16] [R17]
      end
      // stored advertisement goes to the line only on an apply event
      next_adv_active = apply_now ? adv : adv_active_out;   // [R1]
      if (line_in.np_sent) begin
         next_txnp[aps_pkg::NP_TOG_BIT] = ~txnp[aps_pkg::NP_TOG_BIT];  // [R18]
      end
      // partner words replace whole, fields in place [R4] [R5] [R6] [R7] [R8] [R9]
      next_pbase = line_in.base_valid ? line_in.base_word : pbase;
      next_rxnp  = line_in.next_valid ? line_in.next_word : rxnp;      // [R19]
      next_exp_pd   = line_in.pd_fault | (exp_pd & ~rd_exp);           // [R10]
      next_exp_lpnp = line_in.lp_np_able | exp_lpnp;                   // [R11]
      next_exp_pg   = line_in.page_rcvd | (exp_pg & ~rd_exp);          // [R13]
      next_ms_fault_f = line_in.ms_fault |
                        (ms_fault_f & ~rd_ms &
                         ~(line_in.an_complete & ~an_cmp_d));          // [R20]
      // counter saturates rather than wrapping to a misleading small value
      if (line_in.idle_err) begin
         next_idle_cnt = rd_ms ? aps_pkg::CNT_ONE :
                         (idle_cnt == aps_pkg::CNT_MAX) ? idle_cnt :
                         idle_cnt + aps_pkg::CNT_ONE;                  // [R22]
      end else begin
         next_idle_cnt = rd_ms ? 8'h00 : idle_cnt;                     // [R22]
      end
   end

   // software reset returns every field to its default [R4] [R10] [R11] [R20]
   always_ff @(posedge clk_in) begin
      if (!rstn_in || apply_in.sw_reset) begin
         adv              <= aps_pkg::ADV_RST;
         adv_active_out   <= aps_pkg::ADV_RST;
         pbase            <= 16'h0000;
         txnp             <= aps_pkg::TXNP_RST;                       // [R16]
         tx_next_page_out <= aps_pkg::TXNP_RST;
         rxnp             <= 16'h0000;
         exp_pd           <= 1'b0;
         exp_lpnp         <= 1'b0;
         exp_pg           <= 1'b0;
         ms_fault_f       <= 1'b0;
         an_cmp_d         <= 1'b0;
         idle_cnt         <= 8'h00;
      end else begin
         adv              <= next_adv;
         adv_active_out   <= next_adv_active;
         pbase            <= next_pbase;
         txnp             <= next_txnp;
         tx_next_page_out <= next_txnp;
         rxnp             <= next_rxnp;
         exp_pd           <= next_exp_pd;
         exp_lpnp         <= next_exp_lpnp;
         exp_pg           <= next_exp_pg;
         ms_fault_f       <= next_ms_fault_f;
         an_cmp_d         <= line_in.an_complete;
         idle_cnt         <= next_idle_cnt;
      end
   end

   // checks
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in || apply_in.sw_reset);

   sequence pd_then_read;
      line_in.pd_fault ##1 rd_exp;
   endsequence

   adv_t4_zero_a: assert property (adv[aps_pkg::ADV_T4_BIT] == 1'b0)       // [R2]
      else $error("advertisement bit 9 not zero");
   adv_apply_a: assert property (apply_now |=> adv_active_out == $past(adv)) // [R1]
      else $error("advertisement not applied");
   adv_hold_a: assert property (!apply_now |=> $stable(adv_active_out))     // [R1]
      else $error("advertisement applied without trigger");
   pd_latch_a: assert property (pd_then_read |=> rd_sh[aps_pkg::EXP_PD_BIT]) // [R10]
      else $error("parallel fault lost by read");
   pd_clear_a: assert property (rd_exp && !line_in.pd_fault |=> !exp_pd)    // [R10]
      else $error("parallel fault not cleared on read");
   base_load_a: assert property (line_in.base_valid |=>
                                 pbase == $past(line_in.base_word))         // [R4]
      else $error("partner base page not loaded");
   toggle_flip_a: assert property (line_in.np_sent |=>
      txnp[aps_pkg::NP_TOG_BIT] != $past(txnp[aps_pkg::NP_TOG_BIT]))        // [R18]
      else $error("toggle bit not inverted");
   ms_clear_a: assert property (line_in.an_complete && !an_cmp_d &&
                                !line_in.ms_fault |=> !ms_fault_f)          // [R20]
      else $error("fault not cleared at completion");
   idle_read_a: assert property (rd_ms && !line_in.idle_err |=> idle_cnt == 8'h00) // [R22]
      else $error("idle counter not cleared on read");
   ro_write_a: assert property (wr_stb && addr == aps_pkg::PBASE_ADDR &&
                                !line_in.base_valid |=> $stable(pbase))     // [R24]
      else $error("read-only register changed by write");

   // remaining latched flags: a set beats a read clear, the partner next page flag holds, a read with no set clears
   pg_latch_a: assert property (line_in.page_rcvd |=> exp_pg)                // [R13]
      else $error("new page flag not latched");
   lpnp_hold_a: assert property (exp_lpnp |=> exp_lpnp)                      // [R11]
      else $error("partner next page flag dropped");
   ms_set_a: assert property (line_in.ms_fault |=> ms_fault_f)               // [R20]
      else $error("configuration fault not latched");
   ms_rd_clear_a: assert property (rd_ms && !line_in.ms_fault |=> !ms_fault_f) // [R20]
      else $error("configuration fault not cleared on read");
   // counter must stick at full scale instead of wrapping to a small count
   idle_sat_a: assert property (line_in.idle_err && !rd_ms &&          // [R22]
                                idle_cnt == aps_pkg::CNT_MAX |=> idle_cnt == aps_pkg::CNT_MAX)
      else $error("idle counter wrapped");

endmodule
`default_nettype wire

// [inc/aps_pkg.sv]
// Purpose: constants and carriers for the negotiation page register set
// Assumes: 16-bit registers reached by clause 22 management frames
// Notes:   offsets are the 5-bit register addresses carried in the frame
package aps_pkg;
   // register addresses
   localparam logic [4:0] ADV_ADDR   = 5'h04;
   localparam logic [4:0] PBASE_ADDR = 5'h05;
   localparam logic [4:0] EXP_ADDR   = 5'h06;
   localparam logic [4:0] TXNP_ADDR  = 5'h07;
   localparam logic [4:0] RXNP_ADDR  = 5'h08;
   localparam logic [4:0] MS_ADDR    = 5'h0a;
   // reset values and write masks
   localparam logic [15:0] ADV_RST     = 16'h1de1;
   localparam logic [15:0] ADV_WR_MASK = 16'hbde0;
   localparam logic [15:0] TXNP_RST    = 16'h2001;
   localparam logic [15:0] TXNP_WR_MSK = 16'hb7ff;
   localparam logic [15:0] ZERO16      = 16'h0000;
   localparam logic [7:0]  CNT_MAX     = 8'hff;
   localparam logic [7:0]  CNT_ONE     = 8'h01;
   // field positions
   localparam int ADV_T4_BIT   = 9;
   localparam int EXP_PD_BIT   = 4;
   localparam int NP_TOG_BIT   = 11;
   localparam int MS_FAULT_BIT = 15;
   // management frame coding
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ  = 2'h2;
   localparam logic [4:0] HDR_LAST = 5'h0c;   // start bit, opcode, phy and reg address
   localparam logic [4:0] TA_LAST  = 5'h01;
   localparam logic [4:0] DAT_LAST = 5'h0f;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   localparam logic [4:0] CNT_INC  = 5'h01;

   typedef enum logic [1:0] {
      APS_IDLE = 2'h0,
      APS_HDR  = 2'h1,
      APS_TURN = 2'h3,
      APS_DATA = 2'h2
   } aps_state_e;

   // events and levels from the line-side negotiation logic
   typedef struct packed {
      logic        base_valid;
      logic [15:0] base_word;
      logic        next_valid;
      logic [15:0] next_word;
      logic        pd_fault;
      logic        lp_np_able;
      logic        lp_an_able;
      logic        page_rcvd;
      logic        np_sent;
      logic        ms_fault;
      logic        ms_master;
      logic        an_complete;
      logic        idle_err;
   } aps_line_s;

   // conditions that make a new advertisement take effect
   typedef struct packed {
      logic sw_reset;
      logic an_restart;
      logic power_up;
      logic link_down;
   } aps_apply_s;
endpackage

// [tb/aps_mgmt_host.sv]
// Purpose: station management host model driving the serial management port
// Assumes: line has a pull-up, so a released line reads one
// Notes:   clock stands low outside frames; data changes while clock is low
`timescale 1ns/1ps
`default_nettype none
module aps_mgmt_host (
   // management pins
   output logic       mdc_out,
   output logic       mdio_drv_out,
   output logic       mdio_oe_out,
   input  wire logic  mdio_in
);
   // idle: clock parked low, line released to the pull-up
   initial begin
      mdc_out      = 1'b0;
      mdio_drv_out = 1'b0;
      mdio_oe_out  = 1'b0;
   end

   // one whole frame; a read releases the line from turnaround on
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wdata, output logic [15:0] rdata);
      logic [35:0] bits;
      int          i;
      bits  = {4'hf, 2'b01, op, phy, ra, 2'b10, wdata};
      rdata = 16'h0000;
      for (i = 35; i >= 0; i--) begin
         mdio_oe_out  = !(op == aps_pkg::OP_READ && i < 18);
         mdio_drv_out = bits[i];
         #62.5 mdc_out = 1'b1; // 8 MHz, under the 12.5 MHz ceiling
         if (op == aps_pkg::OP_READ && i < 16) begin
            rdata[i] = mdio_in;
         end
         #62.5 mdc_out = 1'b0;
      end
      // release and leave a gap so the synchroniser sees the frame end
      mdio_oe_out = 1'b0;
      #100;
   endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for the negotiation page register set
// Assumes: host model speaks the management frames, bench drives line side
// Notes:   expected values come from the reset values and write masks
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [4:0] PHY = 5'h03;
   localparam logic [4:0] BAD = 5'h04;
   logic               clk_in;
   logic               rstn_in;
   logic               mdc;
   logic               host_bit;
   logic               host_oe;
   logic               mdio_out;
   logic               mdio_oe_out;
   logic               mdio_wire;
   aps_pkg::aps_line_s  lin;
   aps_pkg::aps_line_s  p;
   aps_pkg::aps_apply_s app;
   logic [15:0]        adv_active_out;
   logic [15:0]        tx_next_page_out;
   logic [15:0]        r;
   logic [15:0]        v;
   logic [15:0]        act;
   logic [15:0]        advv [3];
   int                 error_cnt;
   int                 n_compared;
   int                 i;

   // shared wire: whoever enables drives, otherwise the pull-up wins
   assign mdio_wire = mdio_oe_out ? mdio_out : (host_oe ? host_bit : 1'b1);

   aps_regs #(.PHY_ADDR(PHY)) i_dut (
      .clk_in           (clk_in),
      .rstn_in          (rstn_in),
      .mdc_in           (mdc),
      .mdio_in          (mdio_wire),
      .mdio_out         (mdio_out),
      .mdio_oe_out      (mdio_oe_out),
      .line_in          (lin),
      .apply_in         (app),
      .adv_active_out   (adv_active_out),
      .tx_next_page_out (tx_next_page_out)
   );

   aps_mgmt_host i_host (
      .mdc_out      (mdc),
      .mdio_drv_out (host_bit),
      .mdio_oe_out  (host_oe),
      .mdio_in      (mdio_wire)
   );

   // 100 MHz system clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // frames start just after a falling edge so pin edges never meet a rising edge
   task automatic frm(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] a,
                      input logic [15:0] d, output logic [15:0] rr);
      @(negedge clk_in);
      #1;
      i_host.frame(op, phy, a, d, rr);
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] rr;
      frm(aps_pkg::OP_WRITE, PHY, a, d, rr);
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] rr;
      frm(aps_pkg::OP_READ, PHY, a, 16'h0000, rr);
      chk(rr, exp);
   endtask

   // one-cycle line events; levels in lin are left alone
   task automatic pulse(input aps_pkg::aps_line_s ev);
      @(negedge clk_in);
      lin = aps_pkg::aps_line_s'(lin | ev);
      @(negedge clk_in);
      lin = aps_pkg::aps_line_s'(lin & ~ev);
   endtask

   task automatic apply(input aps_pkg::aps_apply_s a);
      @(negedge clk_in);
      app = a;
      @(negedge clk_in);
      app = '0;
      @(negedge clk_in);
   endtask

   task automatic end_of_test;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // watchdog: about 40 frames of 4.6 us plus line pulses, so 400 us is ample
   initial begin
      #400000;
      error_cnt++;
      $display("wrong value at %0t: watchdog expired", $time);
      end_of_test;
   end

   initial begin
      lin     = '0;
      app     = '0;
      rstn_in = 1'b0;
      advv    = '{16'hffff, 16'h0000, 16'h0400};
      repeat (10) @(negedge clk_in);
      rstn_in = 1'b1;
      repeat (5) @(negedge clk_in);
      // reset values and an unmapped address
      chk(adv_active_out, aps_pkg::ADV_RST);
      chk(tx_next_page_out, aps_pkg::TXNP_RST);
      rd(aps_pkg::ADV_ADDR, aps_pkg::ADV_RST);
      rd(aps_pkg::PBASE_ADDR, aps_pkg::ZERO16);
      rd(aps_pkg::EXP_ADDR, 16'h0004);
      rd(aps_pkg::TXNP_ADDR, aps_pkg::TXNP_RST);
      rd(aps_pkg::RXNP_ADDR, aps_pkg::ZERO16);
      rd(aps_pkg::MS_ADDR, aps_pkg::ZERO16);
      rd(5'h1f, aps_pkg::ZERO16);
      // advertisement stored at once, in effect only after each of link down, power up and restart
      act = aps_pkg::ADV_RST;
      for (i = 0; i < 3; i++) begin
         v = (advv[i] & aps_pkg::ADV_WR_MASK) | (aps_pkg::ADV_RST & ~aps_pkg::ADV_WR_MASK);
         wr(aps_pkg::ADV_ADDR, advv[i]);
         rd(aps_pkg::ADV_ADDR, v);
         chk(adv_active_out, act);
         apply(aps_pkg::aps_apply_s'(4'b0001 << i));
         act = v;
         chk(adv_active_out, act);
      end
      // frames for another address are ignored and never answered
      frm(aps_pkg::OP_WRITE, BAD, aps_pkg::ADV_ADDR, 16'hffff, r);
      rd(aps_pkg::ADV_ADDR, 16'h0401);
      frm(aps_pkg::OP_READ, BAD, aps_pkg::ADV_ADDR, 16'h0000, r);
      chk(r, 16'hffff);
      // partner base page
      p = '0;
      p.base_valid = 1'b1;
      p.base_word  = 16'habcd;
      pulse(p);
      rd(aps_pkg::PBASE_ADDR, 16'habcd);
      wr(aps_pkg::PBASE_ADDR, 16'h0000);
      rd(aps_pkg::PBASE_ADDR, 16'habcd);
      // expansion flags: latched, some cleared by reading
      @(negedge clk_in);
      lin.lp_an_able = 1'b1;
      lin.ms_master  = 1'b1;
      p = '0;
      p.pd_fault   = 1'b1;
      p.page_rcvd  = 1'b1;
      p.lp_np_able = 1'b1;
      pulse(p);
      rd(aps_pkg::EXP_ADDR, 16'h001f);
      rd(aps_pkg::EXP_ADDR, 16'h000d);
      // a fault that persists through a read must survive that read's clear
      @(negedge clk_in);
      lin.pd_fault = 1'b1;
      rd(aps_pkg::EXP_ADDR, 16'h001d);
      @(negedge clk_in);
      lin.pd_fault = 1'b0;
      rd(aps_pkg::EXP_ADDR, 16'h001d);
      // transmit and received next page words
      wr(aps_pkg::TXNP_ADDR, 16'hffff);
      rd(aps_pkg::TXNP_ADDR, 16'hb7ff);
      p = '0;
      p.np_sent = 1'b1;
      pulse(p);
      rd(aps_pkg::TXNP_ADDR, 16'hbfff);
      wr(aps_pkg::TXNP_ADDR, 16'h0000);
      rd(aps_pkg::TXNP_ADDR, 16'h0800);
      chk(tx_next_page_out, 16'h0800);
      p = '0;
      p.next_valid = 1'b1;
      p.next_word  = 16'hb9a5;
      pulse(p);
      rd(aps_pkg::RXNP_ADDR, 16'hb9a5);
      // master/slave fault, resolution and idle error count
      p = '0;
      p.ms_fault = 1'b1;
      p.idle_err = 1'b1;
      pulse(p);
      p.ms_fault = 1'b0;
      pulse(p);
      pulse(p);
      rd(aps_pkg::MS_ADDR, 16'hc003);
      rd(aps_pkg::MS_ADDR, 16'h4000);
      p = '0;
      p.ms_fault = 1'b1;
      pulse(p);
      @(negedge clk_in);
      lin.an_complete = 1'b1;
      rd(aps_pkg::MS_ADDR, 16'h4000);
      p = '0;
      p.idle_err = 1'b1;
      repeat (260) pulse(p);
      rd(aps_pkg::MS_ADDR, 16'h40ff);
      // software reset: every register but the received next page word reads back its default
      wr(aps_pkg::ADV_ADDR, 16'h0000);
      apply(aps_pkg::aps_apply_s'(4'b1000));
      chk(adv_active_out, aps_pkg::ADV_RST);
      rd(aps_pkg::ADV_ADDR, aps_pkg::ADV_RST);
      rd(aps_pkg::PBASE_ADDR, aps_pkg::ZERO16);
      rd(aps_pkg::EXP_ADDR, 16'h0005);
      rd(aps_pkg::TXNP_ADDR, aps_pkg::TXNP_RST);
      rd(aps_pkg::MS_ADDR, 16'h4000);
      end_of_test;
   end
endmodule
`default_nettype wire
